/* hdl/fmi_pkg.sv */
// Shared constants for the fault monitor with its serial register slave.
// Assumes a single 125 MHz system clock; temperatures arrive in whole
// degrees Celsius, the supply reading in units of 100 mV.
package fmi_pkg;

  // Register subaddresses
  localparam logic [7:0] REG_THRESHOLD_CONFIG = 8'h09;
  localparam logic [7:0] REG_LATCH_STATUS = 8'h0c;
  localparam logic [7:0] REG_WARNING_STATUS = 8'h0e;
  localparam logic [7:0] REG_INTERRUPT_MASK = 8'h0f;

  // Field positions
  localparam int LATCH_TSD_BIT = 4;
  localparam int WARN_TEMP_BIT = 5;
  localparam int WARN_LVIN_BIT = 4;
  localparam int WARN_USED_W = 6;
  localparam int TH_LVIN_LSB = 0;
  localparam int TH_LVIN_W = 4;
  localparam int TH_HEAT_LSB = 4;
  localparam int TH_HEAT_W = 2;

  // Reset values
  localparam logic [7:0] THRESHOLD_CONFIG_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_MASK_RST = 8'h00;

  // Temperatures in degrees Celsius
  localparam logic [7:0] TSD_ENTER_C = 8'h96;  // 150
  localparam logic [7:0] TSD_EXIT_C = 8'h87;   // 135
  localparam logic [7:0] HEAT_105_C = 8'h69;
  localparam logic [7:0] HEAT_115_C = 8'h73;
  localparam logic [7:0] HEAT_125_C = 8'h7d;

  // Supply threshold in 100 mV units: 4.2 V base, 0.5 V steps, top code 11.2 V
  localparam logic [7:0] LVIN_BASE = 8'h2a;
  localparam logic [7:0] LVIN_STEP = 8'h05;
  localparam logic [3:0] LVIN_TOP_CODE = 4'he;

  // Slave address
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h48;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  // Serial clock limit and the matching period in system cycles
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_PERIOD_CYC = CLK_FREQ_KHZ / SCL_MAX_KHZ;
  localparam int SCL_MIN_SAMPLES = 8;

  // Transaction states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SUB = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_IGNORE = 3'h5
  } fmi_state_t;

endpackage : fmi_pkg

/* hdl/fmi_bus_pins.sv */
// Serial bus pin conditioning: synchronises clock and data lines,
// finds clock edges and start and stop conditions.
// Assumes both lines come straight from pins, outside the clock domain.
`timescale 1ns/1ps
module fmi_bus_pins (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);

  logic [2:0] scl_sh;
  logic [2:0] sda_sh;

  // Two flops per line, third stage only for edge finding
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sh <= 3'h7;
      sda_sh <= 3'h7;
    end else begin
      scl_sh <= {scl_sh[1:0], scl_i};
      sda_sh <= {sda_sh[1:0], sda_i};
    end
  end

  // Events look only at stages two and three
  always_comb begin
    sda_o = sda_sh[1];
    scl_rise_o = scl_sh[1] && !scl_sh[2];
    scl_fall_o = !scl_sh[1] && scl_sh[2];
    start_o = scl_sh[1] && scl_sh[2] && !sda_sh[1] && sda_sh[2];
    stop_o = scl_sh[1] && scl_sh[2] && sda_sh[1] && !sda_sh[2];
  end

endmodule : fmi_bus_pins

/* hdl/fmi_top.sv */
// Fault monitor with serial register slave: thermal shutdown sequencing,
// latched shutdown status, overheat and low-supply warnings, alert output.
// Assumes temperature and supply codes held steady across a few cycles,
// and a bus master on the two-wire lines with external pull-ups.
// Contract
// - Above 150 C all channels off, internal linear regulators stay on.
// - Stay shut down until temperature falls below 135 C.
// - Leaving shutdown starts a new soft start on each enabled channel.
// - Shutdown sets bit 4 of the latch status register.
// - Writing 1 clears the shutdown flag only once the fault is gone.
// - Overheat threshold selectable as 105, 115 or 125 degrees.
// - Exceeding overheat threshold sets warning flag, channels keep running.
// - Warnings latch until written 1, all enables low, or reset.
// - Low supply threshold 4.2 V to 11.2 V in 0.5 V steps.
// - Supply below threshold sets low-input flag, channels keep running.
// - Bus clock up to 400 kHz; master never faster.
// - General call address is neither acknowledged nor acted on.
// - Once a read starts, serve only that master until it finishes.
// - Answer at address 0x48, optionally changed by the select pin.
// - Writing 1 to a status flag clears it, no zero write needed.
// - Every transaction selects its register by a subaddress byte.
// - Data bits are taken on the rising bus clock edge.
// - During reads the slave drives register data on the data line.
// - Alert low while any set warning flag is unmasked; mask resets clear.
// - Reading a flag or writing 0 to it leaves it unchanged.
`timescale 1ns/1ps
module fmi_top #(
  parameter int CHANNELS = 4,
  parameter bit ADDR_PIN_EN = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  input wire logic [7:0] temp_c_i,
  input wire logic [7:0] primary_supply_input_i,
  input wire logic [CHANNELS-1:0] channel_enable_pins_i,
  output logic [CHANNELS-1:0] channel_on_o,
  output logic [CHANNELS-1:0] soft_start_o,
  output logic linear_reg_on_o,
  output logic fault_alert_n_o
);

  // Elaboration checks
  // oversampling margin
  if (fmi_pkg::SCL_MIN_PERIOD_CYC < fmi_pkg::SCL_MIN_SAMPLES) begin : g_rate_chk
    $error("system clock too slow for 400 kHz bus clock");
  end
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_ch_chk
    $error("CHANNELS must be 1 to 8");
  end

  // Overheat threshold from its select field
  function automatic logic [7:0] heat_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = fmi_pkg::HEAT_125_C;
    if (sel == 2'h0) begin
      lim = fmi_pkg::HEAT_105_C;
    end else if (sel == 2'h1) begin
      lim = fmi_pkg::HEAT_115_C;
    end
    return lim;
  endfunction : heat_limit

  // Supply threshold in 100 mV units; codes past the top clamp to 11.2 V
  function automatic logic [7:0] lvin_limit(input logic [3:0] code);
    logic [3:0] c;
    logic [7:0] prod;
    c = (code > fmi_pkg::LVIN_TOP_CODE) ? fmi_pkg::LVIN_TOP_CODE : code;
    prod = 8'({4'h0, c} * fmi_pkg::LVIN_STEP);
    return 8'(fmi_pkg::LVIN_BASE + prod);
  endfunction : lvin_limit

  logic [7:0] threshold_config;
  logic [7:0] interrupt_mask;
  logic [7:0] latch_status;
  logic [7:0] warning_status;

  // Read view of a register by subaddress
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] th,
                                          input logic [7:0] ls, input logic [7:0] ws,
                                          input logic [7:0] im);
    logic [7:0] d;
    d = 8'h00;
    if (a == fmi_pkg::REG_THRESHOLD_CONFIG) begin
      d = th;
    end else if (a == fmi_pkg::REG_LATCH_STATUS) begin
      d = ls;
    end else if (a == fmi_pkg::REG_WARNING_STATUS) begin
      d = ws;
    end else if (a == fmi_pkg::REG_INTERRUPT_MASK) begin
      d = im;
    end
    return d;
  endfunction : reg_read

  // Sensor and enable synchronisers
  logic [7:0] temp_m;
  logic [7:0] temp_s;
  logic [7:0] vin_m;
  logic [7:0] vin_s;
  logic [CHANNELS-1:0] en_m;
  logic [CHANNELS-1:0] en_s;
  logic sel_m;
  logic sel_s;

  // Codes are assumed steady for several cycles, so per-bit skew settles
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_m <= 8'h00;
      temp_s <= 8'h00;
      vin_m <= 8'hff;
      vin_s <= 8'hff;
      en_m <= '0;
      en_s <= '0;
      sel_m <= 1'b0;
      sel_s <= 1'b0;
    end else begin
      temp_m <= temp_c_i;
      temp_s <= temp_m;
      vin_m <= primary_supply_input_i;
      vin_s <= vin_m;
      en_m <= channel_enable_pins_i;
      en_s <= en_m;
      sel_m <= address_select_pin_i;
      sel_s <= sel_m;
    end
  end

  // Address strap caught once the synchroniser has filled after reset
  logic [1:0] strap_cnt;
  logic [6:0] slave_addr;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      slave_addr <= fmi_pkg::SLAVE_ADDR_DEFAULT;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2 && ADDR_PIN_EN) begin
        slave_addr <= {fmi_pkg::SLAVE_ADDR_DEFAULT[6:1], sel_s};
      end
    end
  end

  // Thermal shutdown sequencing
  logic tsd_active;
  logic tsd_exit;
  logic overheat;
  logic low_input;
  always_comb begin
    tsd_exit = tsd_active && (temp_s < fmi_pkg::TSD_EXIT_C);
    overheat = temp_s > heat_limit(threshold_config[fmi_pkg::TH_HEAT_LSB +: fmi_pkg::TH_HEAT_W]);
    low_input = vin_s < lvin_limit(threshold_config[fmi_pkg::TH_LVIN_LSB +: fmi_pkg::TH_LVIN_W]);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tsd_active <= 1'b0;
    end else if (!tsd_active && temp_s > fmi_pkg::TSD_ENTER_C) begin
      tsd_active <= 1'b1;
    end else if (tsd_exit) begin
      tsd_active <= 1'b0;
    end
  end

  // Channel drive; warnings never touch these
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_on_o <= '0;
      soft_start_o <= '0;
      linear_reg_on_o <= 1'b0;
    end else begin
      channel_on_o <= tsd_active ? '0 : en_s;
      linear_reg_on_o <= 1'b1;
      soft_start_o <= tsd_exit ? en_s : '0;
    end
  end

  // Serial bus front end
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  fmi_bus_pins i_fmi_bus_pins (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(bus_start),
    .stop_o(bus_stop)
  );

  fmi_pkg::fmi_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] sub_addr;
  logic [7:0] rd_byte;
  logic ack_phase;
  logic read_lock;
  logic wr_stb;
  logic [7:0] wr_data;
  logic is_rx;
  logic addr_hit;
  logic [7:0] rd_view;

  always_comb begin
    is_rx = (state == fmi_pkg::ST_ADDR) || (state == fmi_pkg::ST_SUB) ||
            (state == fmi_pkg::ST_WDATA);
    addr_hit = (shift[7:1] == slave_addr) && (shift[7:1] != fmi_pkg::GENERAL_CALL_ADDR);
    // Named so its top bit can be picked; a call result cannot be indexed
    rd_view = reg_read(sub_addr, threshold_config, latch_status, warning_status, interrupt_mask);
  end

  // Byte-level transaction sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= fmi_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      sub_addr <= 8'h00;
      rd_byte <= 8'h00;
      ack_phase <= 1'b0;
      read_lock <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      sda_o <= 1'b0;
      if (bus_stop) begin
        state <= fmi_pkg::ST_IDLE;
        sda_oe_o <= 1'b0;
        ack_phase <= 1'b0;
        read_lock <= 1'b0;
      end else if (bus_start && !read_lock) begin
        // starts ignored while a read owns the slave
        state <= fmi_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (is_rx && !ack_phase && bit_cnt < 4'h8) begin
          shift <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == fmi_pkg::ST_RDATA) begin
          if (bit_cnt == 4'h8) begin
            // Master ack slot ends the one-byte read
            state <= fmi_pkg::ST_IGNORE;
            read_lock <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
      end else if (scl_fall) begin
        if (is_rx && ack_phase) begin
          ack_phase <= 1'b0;
          bit_cnt <= 4'h0;
          sda_oe_o <= 1'b0;
          if (state == fmi_pkg::ST_ADDR && shift[0]) begin
            state <= fmi_pkg::ST_RDATA;
            rd_byte <= rd_view;
            sda_oe_o <= !rd_view[7];
            read_lock <= 1'b1;
          end else if (state == fmi_pkg::ST_ADDR) begin
            state <= fmi_pkg::ST_SUB;
          end else if (state == fmi_pkg::ST_SUB) begin
            state <= fmi_pkg::ST_WDATA;
          end else begin
            // only one data byte per write
            state <= fmi_pkg::ST_IGNORE;
          end
        end else if (is_rx && bit_cnt == 4'h8) begin
          if (state == fmi_pkg::ST_ADDR && !addr_hit) begin
            state <= fmi_pkg::ST_IGNORE;
          end else begin
            ack_phase <= 1'b1;
            sda_oe_o <= 1'b1;
            if (state == fmi_pkg::ST_SUB) begin
              sub_addr <= shift;
            end else if (state == fmi_pkg::ST_WDATA) begin
              wr_stb <= 1'b1;
              wr_data <= shift;
            end
          end
        end else if (state == fmi_pkg::ST_RDATA) begin
          sda_oe_o <= (bit_cnt < 4'h8) ? !rd_byte[3'(4'h7 - bit_cnt)] : 1'b0;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      threshold_config <= fmi_pkg::THRESHOLD_CONFIG_RST;
      interrupt_mask <= fmi_pkg::INTERRUPT_MASK_RST;
    end else if (wr_stb) begin
      if (sub_addr == fmi_pkg::REG_THRESHOLD_CONFIG) begin
        threshold_config <= wr_data;
      end else if (sub_addr == fmi_pkg::REG_INTERRUPT_MASK) begin
        interrupt_mask <= {2'h0, wr_data[fmi_pkg::WARN_USED_W-1:0]};
      end
    end
  end

  // Status clears; a live source re-sets the flag in the same cycle
  logic tsd_clr;
  logic temp_clr;
  logic lvin_clr;
  logic all_en_low;
  always_comb begin
    all_en_low = (en_s == '0);
    tsd_clr = wr_stb && sub_addr == fmi_pkg::REG_LATCH_STATUS &&
              wr_data[fmi_pkg::LATCH_TSD_BIT];
    // zero writes and reads leave flags alone
    temp_clr = wr_stb && sub_addr == fmi_pkg::REG_WARNING_STATUS &&
               wr_data[fmi_pkg::WARN_TEMP_BIT];
    lvin_clr = wr_stb && sub_addr == fmi_pkg::REG_WARNING_STATUS &&
               wr_data[fmi_pkg::WARN_LVIN_BIT];
  end

  // Sticky status flags
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_status <= 8'h00;
      warning_status <= 8'h00;
    end else begin
      // set while fault stands beats clear
      latch_status[fmi_pkg::LATCH_TSD_BIT] <= tsd_active ||
          (latch_status[fmi_pkg::LATCH_TSD_BIT] && !tsd_clr);
      warning_status[fmi_pkg::WARN_TEMP_BIT] <= overheat ||
          (warning_status[fmi_pkg::WARN_TEMP_BIT] && !temp_clr && !all_en_low);
      warning_status[fmi_pkg::WARN_LVIN_BIT] <= low_input ||
          (warning_status[fmi_pkg::WARN_LVIN_BIT] && !lvin_clr && !all_en_low);
    end
  end

  // Alert output, open drain style, low when any unmasked warning flag stands
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_alert_n_o <= 1'b1;
    end else begin
      fault_alert_n_o <= !(|(warning_status & interrupt_mask));
    end
  end

endmodule : fmi_top

/* dv/fmi_top_monitor.sv */
// Checker for the fault monitor top: shutdown, recovery, alert, data pin.
// Assumes it is bound to fmi_top and sees only its ports.
`timescale 1ns/1ps
module fmi_top_monitor #(
  parameter int CHANNELS = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] temp_c_i,
  input wire logic [CHANNELS-1:0] channel_enable_pins_i,
  input wire logic [CHANNELS-1:0] channel_on_o,
  input wire logic [CHANNELS-1:0] soft_start_o,
  input wire logic linear_reg_on_o,
  input wire logic fault_alert_n_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Pin is open drain, never driven high
  a_sda_open_drain: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("data line driven high");
  // Device moves the data line only after a clock fall
  a_oe_after_fall: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("data line moved while clock high");
  a_linreg_up: assert property ($past(rst_n_i) |-> linear_reg_on_o)
    else $error("internal regulators off");
  // Synchroniser plus logic latency fits inside five cycles
  a_shutdown_off: assert property ((temp_c_i > fmi_pkg::TSD_ENTER_C) [*5] |->
    channel_on_o == '0 && linear_reg_on_o)
    else $error("channels running above shutdown limit");
  a_hold_shutdown: assert property ((channel_on_o == '0 && temp_c_i >= fmi_pkg::TSD_EXIT_C
    && $stable(channel_enable_pins_i)) [*6] |=> channel_on_o == '0)
    else $error("left shutdown inside hysteresis");
  a_cool_running: assert property ((temp_c_i < fmi_pkg::TSD_EXIT_C
    && $stable(channel_enable_pins_i)) [*6] |-> channel_on_o == channel_enable_pins_i)
    else $error("channel state differs from enables");
  // Pulse leads the channel turn-on by one cycle
  a_soft_start_edge: assert property (|soft_start_o |-> (soft_start_o & channel_on_o) == '0
    ##1 (channel_on_o & $past(soft_start_o)) == $past(soft_start_o))
    else $error("soft start without channel turn on");
  // Mask clears on reset, so no alert until a mask write
  a_alert_quiet: assert property ($rose(rst_n_i) |-> fault_alert_n_o [*8])
    else $error("alert right after reset");

  c_soft_start: cover property (|soft_start_o);
  c_alert: cover property ($fell(fault_alert_n_o));
  c_device_drive: cover property ($rose(sda_oe_o));
endmodule : fmi_top_monitor

bind fmi_top fmi_top_monitor #(.CHANNELS(CHANNELS)) i_fmi_top_monitor (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .temp_c_i(temp_c_i),
  .channel_enable_pins_i(channel_enable_pins_i),
  .channel_on_o(channel_on_o),
  .soft_start_o(soft_start_o),
  .linear_reg_on_o(linear_reg_on_o),
  .fault_alert_n_o(fault_alert_n_o)
);

/* dv/fmi_i2c_host.sv */
// Two-wire bus master model: start, stop, bytes and register access.
// Assumes sda_i is the resolved wire level with a pull-up.
`timescale 1ns/1ps
module fmi_i2c_host (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wt
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    wt(5);
    scl_o = 1'b1;
    wt(5);
    r = sda_i;
    wt(5);
    scl_o = 1'b0;
    wt(5);
  endtask : bit_io
  // Also serves as repeated start
  task automatic start();
    sda_oe_o = 1'b0;
    wt(5);
    scl_o = 1'b1;
    wt(5);
    sda_oe_o = 1'b1;
    wt(5);
    scl_o = 1'b0;
    wt(5);
  endtask : start
  task automatic stop();
    sda_oe_o = 1'b1;
    wt(5);
    scl_o = 1'b1;
    wt(5);
    sda_oe_o = 1'b0;
    wt(10);
  endtask : stop
  // Ninth slot released: ack is the slave pulling low
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io
  task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic k1;
    logic k2;
    logic k3;
    start();
    byte_io({a, 1'b0}, q, k1);
    byte_io(s, q, k2);
    byte_io(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] s, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic k1;
    logic k2;
    logic k3;
    logic k4;
    start();
    byte_io({a, 1'b0}, q, k1);
    byte_io(s, q, k2);
    start();
    byte_io({a, 1'b1}, q, k3);
    byte_io(8'hff, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask : rd
endmodule : fmi_i2c_host

/* dv/fmi_top_bench.sv */
// Bench for the fault monitor: register access, warnings, shutdown.
// Assumes the host model drives the bus; wire resolved here.
`timescale 1ns/1ps
`define CHK(g, e, m) begin \
  checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED at %0t: %s", $time, m); \
  end \
end
module fmi_top_bench;
  logic mclk_i;
  logic rst_n_i;
  logic scl;
  logic host_oe;
  logic sda_w;
  logic dev_sda;
  logic dev_oe;
  logic [7:0] temp;
  logic [7:0] vin;
  logic [3:0] en;
  logic [3:0] ch_on;
  logic [3:0] ss;
  logic [3:0] ss_seen;
  logic lr_on;
  logic alert_n;
  logic ok;
  logic [3:0] lv;
  logic [7:0] hl;
  logic [7:0] vl;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;

  // Pull-up wire: low if any party pulls
  assign sda_w = (host_oe || (dev_oe && !dev_sda)) ? 1'b0 : 1'b1;

  fmi_top #(.CHANNELS(4), .ADDR_PIN_EN(1'b0)) i_fmi_top (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(dev_sda),
    .sda_oe_o(dev_oe),
    .address_select_pin_i(1'b0),
    .temp_c_i(temp),
    .primary_supply_input_i(vin),
    .channel_enable_pins_i(en),
    .channel_on_o(ch_on),
    .soft_start_o(ss),
    .linear_reg_on_o(lr_on),
    .fault_alert_n_o(alert_n)
  );
  fmi_i2c_host i_fmi_i2c_host (
    .mclk_i(mclk_i),
    .sda_i(sda_w),
    .scl_o(scl),
    .sda_oe_o(host_oe)
  );

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Hang guard, well above the expected run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  // One-cycle soft start pulses are collected here
  always @(posedge mclk_i) begin
    if (|ss) begin
      ss_seen <= ss_seen | ss;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic wreg(input logic [7:0] s, input logic [7:0] d);
    logic k;
    i_fmi_i2c_host.wr(fmi_pkg::SLAVE_ADDR_DEFAULT, s, d, k);
    `CHK(k, 1'b1, "write refused")
  endtask : wreg
  task automatic creg(input logic [7:0] s, input logic [7:0] e);
    logic [7:0] d;
    logic k;
    i_fmi_i2c_host.rd(fmi_pkg::SLAVE_ADDR_DEFAULT, s, d, k);
    `CHK(k, 1'b1, "read refused")
    `CHK(d, e, "register value")
  endtask : creg
  // Sensor levels settle well past the 4 cycle latency
  task automatic sense(input logic [7:0] t, input logic [7:0] v);
    @(negedge mclk_i);
    temp = t;
    vin = v;
    repeat (8) @(negedge mclk_i);
  endtask : sense

  initial begin
    rst_n_i = 1'b0;
    temp = 8'h19;
    vin = 8'h78;
    en = 4'hb;
    ss_seen = 4'h0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    `CHK(lr_on, 1'b1, "regulators off")
    `CHK(alert_n, 1'b1, "alert after reset")
    creg(fmi_pkg::REG_THRESHOLD_CONFIG, fmi_pkg::THRESHOLD_CONFIG_RST);
    creg(fmi_pkg::REG_INTERRUPT_MASK, fmi_pkg::INTERRUPT_MASK_RST);
    creg(fmi_pkg::REG_LATCH_STATUS, 8'h00);
    $display("test reset done");
    i_fmi_i2c_host.wr(fmi_pkg::GENERAL_CALL_ADDR, fmi_pkg::REG_THRESHOLD_CONFIG, 8'h3f, ok);
    `CHK(ok, 1'b0, "general call acked")
    i_fmi_i2c_host.wr(fmi_pkg::SLAVE_ADDR_DEFAULT ^ 7'h01, 8'h09, 8'h3f, ok);
    `CHK(ok, 1'b0, "other address acked")
    creg(fmi_pkg::REG_THRESHOLD_CONFIG, 8'h00);
    i_fmi_i2c_host.wr(fmi_pkg::SLAVE_ADDR_DEFAULT, 8'h0b, 8'hff, ok);
    creg(8'h0b, 8'h00);
    $display("test address done");
    // every overheat code, supply code edges
    wreg(fmi_pkg::REG_INTERRUPT_MASK, 8'h20);
    // Fourth pass reaches overheat code 3, which also means 125
    for (int i = 0; i < 4; i++) begin
      lv = (i == 0) ? 4'h0 : (i == 1) ? 4'he : (i == 2) ? 4'hf : 4'h7;
      hl = (i == 0) ? fmi_pkg::HEAT_105_C : (i == 1) ? fmi_pkg::HEAT_115_C : fmi_pkg::HEAT_125_C;
      vl = fmi_pkg::LVIN_BASE + fmi_pkg::LVIN_STEP * ((lv > fmi_pkg::LVIN_TOP_CODE) ?
           fmi_pkg::LVIN_TOP_CODE : lv);
      wreg(fmi_pkg::REG_THRESHOLD_CONFIG, {2'b00, i[1:0], lv});
      creg(fmi_pkg::REG_THRESHOLD_CONFIG, {2'b00, i[1:0], lv});
      sense(hl, vl);
      creg(fmi_pkg::REG_WARNING_STATUS, 8'h00);
      sense(hl + 8'h01, vl - 8'h01);
      creg(fmi_pkg::REG_WARNING_STATUS, 8'h30);
      `CHK(ch_on, 4'hb, "warning stopped channels")
      `CHK(alert_n, 1'b0, "alert missing")
      sense(8'h19, 8'h78);
      wreg(fmi_pkg::REG_WARNING_STATUS, 8'h00);
      creg(fmi_pkg::REG_WARNING_STATUS, 8'h30);
      wreg(fmi_pkg::REG_WARNING_STATUS, 8'h20);
      creg(fmi_pkg::REG_WARNING_STATUS, 8'h10);
      `CHK(alert_n, 1'b1, "masked flag alerts")
      wreg(fmi_pkg::REG_WARNING_STATUS, 8'h10);
      creg(fmi_pkg::REG_WARNING_STATUS, 8'h00);
    end
    $display("test thresholds done");
    sense(8'h19, 8'h29);
    sense(8'h19, 8'h78);
    creg(fmi_pkg::REG_WARNING_STATUS, 8'h10);
    en = 4'h0;
    repeat (8) @(negedge mclk_i);
    `CHK(ch_on, 4'h0, "channels without enable")
    creg(fmi_pkg::REG_WARNING_STATUS, 8'h00);
    en = 4'hb;
    $display("test enables done");
    sense(fmi_pkg::TSD_ENTER_C, 8'h78);
    `CHK(ch_on, 4'hb, "shutdown at limit")
    sense(fmi_pkg::TSD_ENTER_C + 8'h01, 8'h78);
    `CHK(ch_on, 4'h0, "no shutdown")
    `CHK(lr_on, 1'b1, "regulators off")
    creg(fmi_pkg::REG_LATCH_STATUS, 8'h10);
    wreg(fmi_pkg::REG_LATCH_STATUS, 8'h10);
    creg(fmi_pkg::REG_LATCH_STATUS, 8'h10);
    ss_seen = 4'h0;
    sense(fmi_pkg::TSD_EXIT_C, 8'h78);
    `CHK(ch_on, 4'h0, "left shutdown early")
    sense(fmi_pkg::TSD_EXIT_C - 8'h01, 8'h78);
    `CHK(ch_on, 4'hb, "stayed shut down")
    `CHK(ss_seen, 4'hb, "soft start set")
    creg(fmi_pkg::REG_LATCH_STATUS, 8'h10);
    wreg(fmi_pkg::REG_LATCH_STATUS, 8'h10);
    creg(fmi_pkg::REG_LATCH_STATUS, 8'h00);
    $display("test shutdown done");
    stop_test();
  end
endmodule : fmi_top_bench
